/* File: include/imes_regs.vh */
`ifndef IMES_REGS_VH
`define IMES_REGS_VH

// ============================================================
// Register indices. The byte address of each register is four times its index.
`define IMES_IDX_MASK_A      16'hffe4
`define IMES_IDX_MASK_B      16'hffe5
`define IMES_IDX_MASK_C      16'hffe6
`define IMES_IDX_EDGE_A      16'hffec
`define IMES_IDX_EDGE_B      16'hffed
`define IMES_IDX_EXT_STATUS  16'hffee

// ============================================================
// Bus geometry.
`define IMES_ADDR_W          18
`define IMES_IDX_LSB         2
`define IMES_IDX_MSB         17
`define IMES_BYTE_W          8

// ============================================================
// Reset values.
`define IMES_MASK_RESET      8'hff
`define IMES_EDGE_RESET      8'h00
`define IMES_STATUS_RESET    4'h0

// ============================================================
// Field layouts.
`define IMES_WDT_MASK_BIT    0
`define IMES_EXT_MASK_LSB    1
`define IMES_EXT_MASK_MSB    4
`define IMES_EDGE_A_KEEP     8'hfc
`define IMES_EDGE_B_KEEP     8'h03
`define IMES_MASK_C_FIXED    8'hc0
`define IMES_EDGE_A_LSB      2
`define IMES_EDGE_A_MSB      7
`define IMES_EDGE_B_LSB      0
`define IMES_EDGE_B_MSB      1

// ============================================================
// Edge codes per two-bit field.
`define IMES_EDGE_FALL       2'b00
`define IMES_EDGE_RISE       2'b01
`define IMES_EDGE_BAD        2'b10
`define IMES_EDGE_BOTH       2'b11

// ============================================================
// Watchdog modes and the value a masked-out watchdog mask read returns.
`define IMES_WDT_MODE1       2'b01
`define IMES_WDT_MODE2       2'b10
`define IMES_WDT_UNDEF       1'b0

// ============================================================
// Bus responses.
`define IMES_RESP_OKAY       2'b00
`define IMES_RESP_SLVERR     2'b10

`endif

/* File: src/imes_irq_mask_edge.v */
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "imes_regs.vh"

module imes_irq_mask_edge (
  input  wire                     ref_clk,
  input  wire                     rstn,
  input  wire [`IMES_ADDR_W-1:0]  s_axi_awaddr,
  input  wire                     s_axi_awvalid,
  output reg                      s_axi_awready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output reg                      s_axi_wready,
  output reg  [1:0]               s_axi_bresp,
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  input  wire [`IMES_ADDR_W-1:0]  s_axi_araddr,
  input  wire                     s_axi_arvalid,
  output reg                      s_axi_arready,
  output reg  [31:0]              s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  input  wire [1:0]               wdtMode,
  input  wire [3:0]               extIrqPin,
  input  wire [23:0]              srcRequest,
  output reg  [23:0]              srcServiceable,
  output reg  [3:0]               extIrqFlag,
  output reg                      irq
);

  // ============================================================
  // Storage.
  reg  [7:0]               interruptMaskFlagsA;
  reg  [7:0]               interruptMaskFlagsB;
  reg  [7:0]               interruptMaskFlagsC;
  reg  [7:0]               extEdgeModeA;
  reg  [7:0]               extEdgeModeB;
  reg  [3:0]               prevPin;
  reg                      pinArmed;
  reg                      awHeld;
  reg                      wHeld;
  reg  [`IMES_ADDR_W-1:0]  awAddr;
  reg  [31:0]              wData;
  reg  [3:0]               wStrb;

  // One-hot select positions returned by the address decode.
  localparam SEL_MASK_A     = 0;
  localparam SEL_MASK_B     = 1;
  localparam SEL_MASK_C     = 2;
  localparam SEL_EDGE_A     = 3;
  localparam SEL_EDGE_B     = 4;
  localparam SEL_EXT_STATUS = 5;

  // ============================================================
  // Address decode shared by both bus directions.
  function [5:0] regSel;
    input [`IMES_ADDR_W-1:0] addr;
    reg   [15:0]             idx;
    begin
      idx    = addr[`IMES_IDX_MSB:`IMES_IDX_LSB];
      regSel = 6'h00;
      if (addr[`IMES_IDX_LSB-1:0] == 2'b00) begin
        regSel[SEL_MASK_A]     = (idx == `IMES_IDX_MASK_A);
        regSel[SEL_MASK_B]     = (idx == `IMES_IDX_MASK_B);
        regSel[SEL_MASK_C]     = (idx == `IMES_IDX_MASK_C);
        regSel[SEL_EDGE_A]     = (idx == `IMES_IDX_EDGE_A);
        regSel[SEL_EDGE_B]     = (idx == `IMES_IDX_EDGE_B);
        regSel[SEL_EXT_STATUS] = (idx == `IMES_IDX_EXT_STATUS);
      end
    end
  endfunction

  // One edge field turns a pin's old and new level into a trigger.
  function edgeHit;
    input [1:0] mode;
    input       oldLvl;
    input       newLvl;
    begin
      case (mode)
        `IMES_EDGE_FALL: edgeHit = oldLvl & ~newLvl;
        `IMES_EDGE_RISE: edgeHit = ~oldLvl & newLvl;
        `IMES_EDGE_BOTH: edgeHit = oldLvl ^ newLvl;
        default:         edgeHit = 1'b0;
      endcase
    end
  endfunction

  // Any access that hits no register is answered with a slave error.
  function [1:0] respFor;
    input [5:0] sel;
    begin
      respFor = (|sel) ? `IMES_RESP_OKAY : `IMES_RESP_SLVERR;
    end
  endfunction

  // ============================================================
  // Edge detection and the sticky external request flags.
  wire [7:0]  edgeFields = {extEdgeModeB[`IMES_EDGE_B_MSB:`IMES_EDGE_B_LSB],
                            extEdgeModeA[`IMES_EDGE_A_MSB:`IMES_EDGE_A_LSB]};
  wire [3:0]  extMask    = interruptMaskFlagsA[`IMES_EXT_MASK_MSB:`IMES_EXT_MASK_LSB];
  wire        doWrite    = awHeld & wHeld & ~s_axi_bvalid;
  wire [5:0]  wSel       = regSel(awAddr);
  wire        byteWrite  = wStrb[0];
  wire        doStore    = doWrite & byteWrite;
  wire [7:0]  wByte      = wData[`IMES_BYTE_W-1:0];
  wire [23:0] maskAll    = {interruptMaskFlagsC, interruptMaskFlagsB, interruptMaskFlagsA};

  reg  [3:0]  edgeEvent;
  reg  [3:0]  statusClear;
  reg  [3:0]  next_extIrqFlag;
  integer     n;

  always @* begin
    edgeEvent = 4'h0;
    // The pins are watched with no regard to port direction, so a pin
    // driven as an output still raises its flag.
    for (n = 0; n < 4; n = n + 1) begin
      edgeEvent[n] = pinArmed &
                     edgeHit(edgeFields[2*n +: 2], prevPin[n], extIrqPin[n]);
    end
    statusClear     = (doStore & wSel[SEL_EXT_STATUS]) ? wData[3:0] : 4'h0;
    // A new edge beats a write-one-to-clear in the same cycle.
    next_extIrqFlag = (extIrqFlag & ~statusClear) | edgeEvent;
  end

  // Detection stays disarmed for the first cycle after reset, so a pin
  // that already sits high when reset lifts is not mistaken for an edge.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prevPin  <= 4'h0;
      pinArmed <= 1'b0;
    end else begin
      prevPin  <= extIrqPin;
      pinArmed <= 1'b1;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      extIrqFlag     <= `IMES_STATUS_RESET;
      irq            <= 1'b0;
      srcServiceable <= 24'h000000;
    end else begin
      extIrqFlag     <= next_extIrqFlag;
      // The line follows the flags as they will stand, so it rises in the
      // same cycle as the flag that causes it.
      irq            <= |(next_extIrqFlag & ~extMask);
      srcServiceable <= srcRequest & ~maskAll;
    end
  end

  // ============================================================
  // Register file. A store happens in the cycle that raises the write
  // response; a write whose low byte strobe is clear changes nothing.
  reg  [7:0]  next_interruptMaskFlagsA;
  reg  [7:0]  next_interruptMaskFlagsB;
  reg  [7:0]  next_interruptMaskFlagsC;
  reg  [7:0]  next_extEdgeModeA;
  reg  [7:0]  next_extEdgeModeB;

  always @* begin
    next_interruptMaskFlagsA = interruptMaskFlagsA;
    next_interruptMaskFlagsB = interruptMaskFlagsB;
    next_interruptMaskFlagsC = interruptMaskFlagsC;
    next_extEdgeModeA        = extEdgeModeA;
    next_extEdgeModeB        = extEdgeModeB;
    if (doStore) begin
      if (wSel[SEL_MASK_A]) begin
        next_interruptMaskFlagsA = wByte;
      end
      if (wSel[SEL_MASK_B]) begin
        next_interruptMaskFlagsB = wByte;
      end
      // The two top bits of the third mask register have no source behind
      // them and always read as one.
      if (wSel[SEL_MASK_C]) begin
        next_interruptMaskFlagsC = wByte | `IMES_MASK_C_FIXED;
      end
      // Edge modes change only on a whole-byte write, and the bits that
      // must stay zero are never stored.
      if (wSel[SEL_EDGE_A]) begin
        next_extEdgeModeA = wByte & `IMES_EDGE_A_KEEP;
      end
      if (wSel[SEL_EDGE_B]) begin
        next_extEdgeModeB = wByte & `IMES_EDGE_B_KEEP;
      end
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      interruptMaskFlagsA <= `IMES_MASK_RESET;
      interruptMaskFlagsB <= `IMES_MASK_RESET;
      interruptMaskFlagsC <= `IMES_MASK_RESET;
      extEdgeModeA        <= `IMES_EDGE_RESET;
      extEdgeModeB        <= `IMES_EDGE_RESET;
    end else begin
      interruptMaskFlagsA <= next_interruptMaskFlagsA;
      interruptMaskFlagsB <= next_interruptMaskFlagsB;
      interruptMaskFlagsC <= next_interruptMaskFlagsC;
      extEdgeModeA        <= next_extEdgeModeA;
      extEdgeModeB        <= next_extEdgeModeB;
    end
  end

  // ============================================================
  // Write channel. Address and data may arrive in either order; the
  // write lands one cycle after both are held. Only the low byte lane
  // is honoured, since every register is a single byte wide.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IMES_RESP_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= {`IMES_ADDR_W{1'b0}};
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        awHeld        <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wHeld        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= respFor(wSel);
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ============================================================
  // Read channel. One read at a time; data answers the cycle after
  // the address is taken.
  wire [5:0] rSel     = regSel(s_axi_araddr);
  wire       wdtBusy  = (wdtMode == `IMES_WDT_MODE1) || (wdtMode == `IMES_WDT_MODE2);
  reg  [7:0] readByte;

  always @* begin
    readByte = 8'h00;
    case (1'b1)
      rSel[SEL_MASK_A]: begin
        readByte = interruptMaskFlagsA;
        // The watchdog mask carries no defined value while the watchdog
        // owns it; a fixed value keeps simulation free of unknowns.
        if (wdtBusy) begin
          readByte[`IMES_WDT_MASK_BIT] = `IMES_WDT_UNDEF;
        end
      end
      rSel[SEL_MASK_B]:     readByte = interruptMaskFlagsB;
      rSel[SEL_MASK_C]:     readByte = interruptMaskFlagsC;
      rSel[SEL_EDGE_A]:     readByte = extEdgeModeA;
      rSel[SEL_EDGE_B]:     readByte = extEdgeModeB;
      rSel[SEL_EXT_STATUS]: readByte = {4'h0, extIrqFlag};
      default: readByte = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `IMES_RESP_OKAY;
    end else begin
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, readByte};
        s_axi_rresp   <= respFor(rSel);
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* File: tb/imes_irq_mask_edge_asserts.sv */
`timescale 1ns/10ps
// ============================================================
// Port-level checks; only the outputs that the block drives are judged.
module imes_chk (
  input wire        ref_clk,
  input wire        rstn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [3:0]  extIrqPin,
  input wire [23:0] srcRequest,
  input wire [23:0] srcServiceable,
  input wire [3:0]  extIrqFlag,
  input wire        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  chk_serv_subset: assert property (
    (srcServiceable & ~$past(srcRequest)) == 24'h0) else $error("service without request");
  chk_serv_fixed: assert property (
    srcServiceable[23:22] == 2'b00) else $error("fixed mask bits let a request through");
  chk_irq_cause: assert property (
    irq |-> extIrqFlag != 4'h0) else $error("irq without a pending flag");
  // A new flag needs a level change between the two previous pin samples.
  chk_flag_edge: assert property (
    (extIrqFlag & ~$past(extIrqFlag) & ~($past(extIrqPin) ^ $past(extIrqPin, 2))) == 4'h0)
    else $error("flag set without a pin edge");
  chk_flag_sticky: assert property (
    (($past(extIrqFlag) & ~extIrqFlag) != 4'h0) |-> $rose(s_axi_bvalid))
    else $error("flag dropped without a write");
  chk_write_walk: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
  chk_read_walk: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer timing");
  chk_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_rdata_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("read data above bit 7");
endmodule

bind imes_irq_mask_edge imes_chk imes_chk_i (.*);

/* File: tb/imes_irq_mask_edge_test.sv */
`timescale 1ns/10ps
`include "imes_regs.vh"
// ============================================================
// Bench: software-style register traffic and pin edges.
module imes_irq_mask_edge_test;
  reg         ref_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  reg         s_axi_rready;
  reg  [17:0] s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb, extIrqPin;
  reg  [1:0]  wdtMode;
  reg  [23:0] srcRequest;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] srcServiceable;
  wire [3:0]  extIrqFlag;
  integer     errors, samplesChecked, i;
  reg  [1:0]  c;

  imes_irq_mask_edge imes_irq_mask_edge_i (.*);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task ck(input string nm, input [31:0] e, input [31:0] g);
    samplesChecked = samplesChecked + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task idle(input integer k);
    repeat (k) @(posedge ref_clk);
  endtask

  // ============================================================
  // Bus master; each channel is released only once it has been taken.
  // It waits for the answer as long as it takes; only the watchdog ends a hang.
  task wr(input [15:0] idx, input [7:0] d, input [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    ck("bresp", er, s_axi_bresp);
  endtask

  task rd(input [15:0] idx, input [7:0] d, input [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    ck("rdata", {24'h0, d}, s_axi_rdata);
    ck("rresp", er, s_axi_rresp);
  endtask

  // ============================================================
  // Scenarios.
  task t_mask;
    srcRequest <= 24'hffffff;
    wr(`IMES_IDX_MASK_A, 8'h00, 2'b00);
    wr(`IMES_IDX_MASK_B, 8'h5a, 2'b00);
    wr(`IMES_IDX_MASK_C, 8'h00, 2'b00);
    rd(`IMES_IDX_MASK_C, 8'hc0, 2'b00);
    idle(2);
    ck("serviceable", 24'h3fa5ff, srcServiceable);
    wr(`IMES_IDX_MASK_A, 8'h01, 2'b00);
    for (i = 0; i < 4; i = i + 1) begin
      wdtMode <= i[1:0];
      idle(1);
      rd(`IMES_IDX_MASK_A, (i == 1 || i == 2) ? 8'h00 : 8'h01, 2'b00);
    end
    // A write without the low byte strobe is answered but stores nothing.
    s_axi_wstrb <= 4'he;
    wr(`IMES_IDX_MASK_B, 8'h00, 2'b00);
    s_axi_wstrb <= 4'hf;
    rd(`IMES_IDX_MASK_B, 8'h5a, 2'b00);
  endtask

  task t_edge;
    for (i = 0; i < 4; i = i + 1) begin
      c = i[1:0];
      wr(`IMES_IDX_MASK_A, 8'hff, 2'b00);
      idle(1);
      ck("irq masked", 0, irq);
      wr(`IMES_IDX_EDGE_A, {c, c, c, 2'b11}, 2'b00);
      wr(`IMES_IDX_EDGE_B, {6'h3f, c}, 2'b00);
      rd(`IMES_IDX_EDGE_A, {c, c, c, 2'b00}, 2'b00);
      rd(`IMES_IDX_EDGE_B, {6'h00, c}, 2'b00);
      wr(`IMES_IDX_EXT_STATUS, 8'h0f, 2'b00);
      wr(`IMES_IDX_MASK_A, 8'h00, 2'b00);
      extIrqPin <= 4'hf;
      idle(3);
      ck("rise flags", c[0] ? 4'hf : 4'h0, extIrqFlag);
      ck("irq", c[0], irq);
      wr(`IMES_IDX_EXT_STATUS, 8'h0f, 2'b00);
      idle(1);
      ck("cleared", 0, extIrqFlag);
      extIrqPin <= 4'h0;
      idle(3);
      ck("fall flags", (c == 2'b00 || c == 2'b11) ? 4'hf : 4'h0, extIrqFlag);
    end
  endtask

  task report_and_stop;
    $display("errors=%0d checks=%0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    errors = 0;
    samplesChecked = 0;
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 68'h0;
    s_axi_wstrb = 4'hf;
    {extIrqPin, wdtMode, srcRequest} = 30'h0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`IMES_IDX_MASK_A, 8'hff, 2'b00);
    rd(`IMES_IDX_MASK_B, 8'hff, 2'b00);
    rd(`IMES_IDX_EDGE_A, 8'h00, 2'b00);
    rd(`IMES_IDX_EDGE_B, 8'h00, 2'b00);
    t_mask;
    t_edge;
    wr(16'hffe7, 8'h55, 2'b10);
    rd(16'hffe7, 8'h00, 2'b10);
    report_and_stop;
  end

  // A hang in a handshake is cut short well beyond the few hundred cycles needed.
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors = errors + 1;
    report_and_stop;
  end
endmodule
